// ===== core/wig_defs.svh
// Register offsets, field positions and reset values of the wake gating block
`ifndef WIG_DEFS_SVH
`define WIG_DEFS_SVH

// Register byte offsets
`define WIG_ADDR_MODE      8'h00
`define WIG_ADDR_WAKE_EN   8'h04
`define WIG_ADDR_INT_EN    8'h08
`define WIG_ADDR_FLAG1     8'h0C
`define WIG_ADDR_FLAG2     8'h10
`define WIG_ADDR_STATUS    8'h14
`define WIG_ADDR_EVT_STAT  8'h18
`define WIG_ADDR_EVT_CLR   8'h1C
`define WIG_ADDR_EVT_EN    8'h20

// Field positions
`define WIG_PC_WAKE_BIT    4
`define WIG_PC_INT_BIT     1
`define WIG_EXT_INT_BIT    2
`define WIG_FLAG_EXT0_BIT  0
`define WIG_FLAG_PC_BIT    1
`define WIG_FLAG_EXT1_BIT  0
`define WIG_EVT_WAKE_BIT   0
`define WIG_EVT_VEC_BIT    1
`define WIG_EVT_RST_BIT    2

// Input vector positions
`define WIG_IN_EXT0        0
`define WIG_IN_EXT1        1
`define WIG_IN_PORT6_LO    2
`define WIG_IN_PORT6_HI    9
`define WIG_IN_WDOG        10
`define WIG_IN_LVR         11

// Values
`define WIG_VEC_ADDR       8'h08
`define WIG_EVT_RESET      3'h0
`define WIG_RESP_OKAY      2'h0
`define WIG_RESP_SLVERR    2'h2

`endif

// ===== core/wig_pkg.sv
// Types shared by the wake gating block
package wig_pkg;

  // Power modes, Gray coded along normal-green-idle-sleep
  typedef enum logic [1:0] {
    WIG_NORMAL = 2'h0,
    WIG_GREEN  = 2'h1,
    WIG_IDLE   = 2'h3,
    WIG_SLEEP  = 2'h2
  } wig_mode_e;

  typedef struct packed {
    logic pc_wake_en;
    logic pc_int_en;
    logic ext_int_en;
  } wig_cfg_s;

  typedef struct packed {
    logic ext0;
    logic ext1;
    logic pc;
  } wig_flags_s;

  typedef struct packed {
    logic [7:0] vec_addr;
    logic       wake;
    logic       vector;
    logic       resume;
    logic       reset;
    logic       osc_run;
  } wig_core_s;

endpackage

// ===== core/wig_sync_edge.sv
// Two-flop synchronisers with rise and change detection per input bit
`timescale 1ns/1ps
`default_nettype none
module wig_sync_edge
#(
  parameter int WIDTH = 12
)
(
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Asynchronous inputs
  input  wire logic [WIDTH-1:0] async_in,
  // Detected events, one cycle each
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] change
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      logic meta_q;
      logic sync_q;
      logic last_q;
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          last_q <= 1'b0;
        end
        else
        begin
          meta_q <= async_in[gi];
          sync_q <= meta_q;
          last_q <= sync_q;
        end
      end
      assign rise[gi]   = sync_q & ~last_q;
      assign change[gi] = sync_q ^ last_q;
    end
  endgenerate

endmodule // wig_sync_edge
`default_nettype wire

// ===== core/wig_wake_gate.sv
// Wake-up and interrupt gating across four power modes, AXI4-Lite registers
// Function
// - Enabled source vectors if interrupts are on; a wake without a vector resumes.
// - Wake applies only in sleep or idle; green and normal only interrupt.
// - Watchdog or low-voltage reset in any mode resets into normal mode.
// - Pins never wake sleep; idle, enabled, interrupts off: wake and flag.
// - Pin enable and interrupts on, outside sleep: flag and vector to 0x08.
// - Green or normal, interrupts off: a pin event sets its flag, no branch.
// - Sleep or idle, both port-change enables clear: no wake, clocks stopped.
// - Green or normal, port-change interrupt enable clear: no interrupt.
// - Sleep or idle, only port-change interrupt enable: flag set, no wake.
// - Sleep or idle, only port-change wake enable: wake to next instruction.
// - In sleep or idle with no wake, oscillator and timer stay stopped.
// - Port change with both interrupt enables on: flag, vector, maybe wake; in sleep or idle the vector needs the wake enable.
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "wig_defs.svh"
module wig_wake_gate
  import wig_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  // Pins
  input  wire logic       external_pin0,
  input  wire logic       external_pin1,
  input  wire logic [7:0] port6,
  input  wire logic       watchdog_timer_timeout,
  input  wire logic       low_voltage_reset,
  // Core instruction strobes
  input  wire logic       global_int_on_instr,
  input  wire logic       global_int_off_instr,
  // Core control and interrupt
  output wig_core_s       core_ctrl,
  output logic            irq
);

  // Input synchronisation
  logic [11:0] in_rise;
  logic [11:0] in_chg;

  wig_sync_edge #(.WIDTH(12)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({low_voltage_reset, watchdog_timer_timeout, port6,
                external_pin1, external_pin0}),
    .rise     (in_rise),
    .change   (in_chg)
  );

  // State
  wig_mode_e  mode_q;
  wig_mode_e  mode_d;
  wig_cfg_s   cfg_q;
  wig_cfg_s   cfg_d;
  wig_flags_s flags_q;
  wig_flags_s flags_d;
  wig_core_s  core_d;
  logic       gie_q;
  logic       gie_d;
  logic [2:0] evt_stat_q;
  logic [2:0] evt_stat_d;
  logic [2:0] evt_en_q;
  logic [2:0] evt_set;

  // Source decisions
  wire sleepish  = (mode_q == WIG_SLEEP) || (mode_q == WIG_IDLE);
  wire rst_ev    = in_rise[`WIG_IN_WDOG] | in_rise[`WIG_IN_LVR];
  wire pc_ev     = |in_chg[`WIG_IN_PORT6_HI:`WIG_IN_PORT6_LO];
  wire ext_ok    = cfg_q.ext_int_en && (mode_q != WIG_SLEEP) && !rst_ev;
  wire ext0_hit  = ext_ok && in_rise[`WIG_IN_EXT0];
  wire ext1_hit  = ext_ok && in_rise[`WIG_IN_EXT1];
  wire ext_any   = ext0_hit || ext1_hit;
  wire ext_wake  = ext_any && (mode_q == WIG_IDLE);
  wire ext_vec   = ext_any && gie_q;
  wire pc_hit    = pc_ev && !rst_ev;
  wire pc_wake   = pc_hit && sleepish && cfg_q.pc_wake_en;
  wire pc_flag   = pc_hit && cfg_q.pc_int_en;
  wire pc_vec    = pc_flag && gie_q
                   && (!sleepish || cfg_q.pc_wake_en);
  wire do_wake   = ext_wake || pc_wake;
  wire do_vec    = ext_vec || pc_vec;
  wire do_resume = do_wake && !do_vec;

  // AXI write path
  logic       aw_hold_q;
  logic [7:0] aw_addr_q;
  logic       w_hold_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  wire        aw_hs    = s_axi_awvalid && s_axi_awready;
  wire        w_hs     = s_axi_wvalid && s_axi_wready;
  wire        aw_have  = aw_hold_q || aw_hs;
  wire        w_have   = w_hold_q || w_hs;
  wire        do_write = aw_have && w_have && !s_axi_bvalid;
  wire [7:0]  wr_raw   = aw_hold_q ? aw_addr_q : s_axi_awaddr;
  wire [7:0]  wr_addr  = {wr_raw[7:2], 2'b00};
  wire [31:0] wr_data  = w_hold_q ? w_data_q : s_axi_wdata;
  wire [3:0]  wr_strb  = w_hold_q ? w_strb_q : s_axi_wstrb;
  wire        wr_en    = do_write && wr_strb[0];

  wire sel_mode  = wr_addr == `WIG_ADDR_MODE;
  wire sel_wake  = wr_addr == `WIG_ADDR_WAKE_EN;
  wire sel_int   = wr_addr == `WIG_ADDR_INT_EN;
  wire sel_flag1 = wr_addr == `WIG_ADDR_FLAG1;
  wire sel_flag2 = wr_addr == `WIG_ADDR_FLAG2;
  wire sel_eclr  = wr_addr == `WIG_ADDR_EVT_CLR;
  wire sel_een   = wr_addr == `WIG_ADDR_EVT_EN;
  wire wr_hit    = sel_mode || sel_wake || sel_int || sel_flag1
                   || sel_flag2 || sel_eclr || sel_een;

  wire       wr_mode   = wr_en && sel_mode;
  wire       wr_cfgw   = wr_en && sel_wake;
  wire       wr_cfgi   = wr_en && sel_int;
  wire       clr_ext0  = wr_en && sel_flag1
                         && wr_data[`WIG_FLAG_EXT0_BIT];
  wire       clr_pc    = wr_en && sel_flag1 && wr_data[`WIG_FLAG_PC_BIT];
  wire       clr_ext1  = wr_en && sel_flag2
                         && wr_data[`WIG_FLAG_EXT1_BIT];
  wire [2:0] evt_clr   = (wr_en && sel_eclr) ? wr_data[2:0] : 3'h0;
  wire       wr_een    = wr_en && sel_een;

  // Next state
  assign mode_d = rst_ev  ? WIG_NORMAL :
                  do_wake ? WIG_NORMAL :
                  wr_mode ? wig_mode_e'(wr_data[1:0]) : mode_q;

  assign cfg_d.pc_wake_en = wr_cfgw ? wr_data[`WIG_PC_WAKE_BIT]
                                    : cfg_q.pc_wake_en;
  assign cfg_d.pc_int_en  = wr_cfgi ? wr_data[`WIG_PC_INT_BIT]
                                    : cfg_q.pc_int_en;
  assign cfg_d.ext_int_en = wr_cfgi ? wr_data[`WIG_EXT_INT_BIT]
                                    : cfg_q.ext_int_en;

  // Set wins over a software clear in the same cycle
  assign flags_d.ext0 = ext0_hit || (flags_q.ext0 && !clr_ext0);
  assign flags_d.ext1 = ext1_hit || (flags_q.ext1 && !clr_ext1);
  assign flags_d.pc   = pc_flag || (flags_q.pc && !clr_pc);

  assign gie_d = rst_ev               ? 1'b0 :
                 global_int_on_instr  ? 1'b1 :
                 global_int_off_instr ? 1'b0 : gie_q;

  assign evt_set    = {rst_ev, do_vec, do_wake};
  assign evt_stat_d = evt_set | (evt_stat_q & ~evt_clr);

  assign core_d.vec_addr = `WIG_VEC_ADDR;
  assign core_d.wake     = do_wake;
  assign core_d.vector   = do_vec;
  assign core_d.resume   = do_resume;
  assign core_d.reset    = rst_ev;
  assign core_d.osc_run  = (mode_d != WIG_SLEEP)
                           && (mode_d != WIG_IDLE);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_q     <= WIG_NORMAL;
      cfg_q      <= '0;
      flags_q    <= '0;
      gie_q      <= 1'b0;
      evt_stat_q <= `WIG_EVT_RESET;
      evt_en_q   <= `WIG_EVT_RESET;
      core_ctrl  <= '0;
      irq        <= 1'b0;
    end
    else
    begin
      mode_q     <= mode_d;
      cfg_q      <= cfg_d;
      flags_q    <= flags_d;
      gie_q      <= gie_d;
      evt_stat_q <= evt_stat_d;
      evt_en_q   <= wr_een ? wr_data[2:0] : evt_en_q;
      core_ctrl  <= core_d;
      irq        <= |(evt_stat_d & (wr_een ? wr_data[2:0] : evt_en_q));
    end
  end

  // AXI write handshake
  wire aw_hold_d = aw_have && !do_write;
  wire w_hold_d  = w_have && !do_write;
  wire bvalid_d  = do_write || (s_axi_bvalid && !s_axi_bready);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WIG_RESP_OKAY;
    end
    else
    begin
      aw_hold_q     <= aw_hold_d;
      w_hold_q      <= w_hold_d;
      aw_addr_q     <= aw_hs ? s_axi_awaddr : aw_addr_q;
      w_data_q      <= w_hs ? s_axi_wdata : w_data_q;
      w_strb_q      <= w_hs ? s_axi_wstrb : w_strb_q;
      s_axi_awready <= !aw_hold_d && !bvalid_d;
      s_axi_wready  <= !w_hold_d && !bvalid_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= do_write ? (wr_hit ? `WIG_RESP_OKAY
                                          : `WIG_RESP_SLVERR)
                                : s_axi_bresp;
    end
  end

  // AXI read path
  wire       ar_hs    = s_axi_arvalid && s_axi_arready;
  wire       rvalid_d = ar_hs || (s_axi_rvalid && !s_axi_rready);
  wire [7:0] rd_addr  = {s_axi_araddr[7:2], 2'b00};
  logic [31:0] rd_data;
  logic        rd_hit;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (rd_addr)
      `WIG_ADDR_MODE:     rd_data[1:0] = mode_q;
      `WIG_ADDR_WAKE_EN:  rd_data[`WIG_PC_WAKE_BIT] = cfg_q.pc_wake_en;
      `WIG_ADDR_INT_EN:
      begin
        rd_data[`WIG_PC_INT_BIT]  = cfg_q.pc_int_en;
        rd_data[`WIG_EXT_INT_BIT] = cfg_q.ext_int_en;
      end
      `WIG_ADDR_FLAG1:
      begin
        rd_data[`WIG_FLAG_EXT0_BIT] = flags_q.ext0;
        rd_data[`WIG_FLAG_PC_BIT]   = flags_q.pc;
      end
      `WIG_ADDR_FLAG2:    rd_data[`WIG_FLAG_EXT1_BIT] = flags_q.ext1;
      `WIG_ADDR_STATUS:   rd_data[2:0] = {mode_q, gie_q};
      `WIG_ADDR_EVT_STAT: rd_data[2:0] = evt_stat_q;
      `WIG_ADDR_EVT_CLR:  rd_data = 32'h0000_0000;
      `WIG_ADDR_EVT_EN:   rd_data[2:0] = evt_en_q;
      default:            rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `WIG_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rdata   <= ar_hs ? rd_data : s_axi_rdata;
      s_axi_rresp   <= ar_hs ? (rd_hit ? `WIG_RESP_OKAY
                                       : `WIG_RESP_SLVERR)
                             : s_axi_rresp;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_low_power_change;
    sleepish && pc_ev && !rst_ev && cfg_q.pc_wake_en;
  endsequence

  sequence s_woken_running;
    core_ctrl.wake && core_ctrl.osc_run ##1 mode_q == WIG_NORMAL;
  endsequence

  a_reset_to_normal: assert property (
    rst_ev |=> core_ctrl.reset && mode_q == WIG_NORMAL
               && !core_ctrl.vector && !gie_q)
    else $error("reset event did not force normal mode");

  a_wake_low_power: assert property (
    core_ctrl.wake |-> $past(sleepish))
    else $error("wake raised outside sleep or idle");

  a_sleep_pin_ignored: assert property (
    mode_q == WIG_SLEEP && !pc_ev && !rst_ev |=> !core_ctrl.wake)
    else $error("external pin woke core from sleep");

  a_vector_addr: assert property (
    ext_any && gie_q |=> core_ctrl.vector
                         && core_ctrl.vec_addr == 8'h08
                         && (flags_q.ext0 || flags_q.ext1))
    else $error("pin event with interrupts on did not vector to 0x08");

  a_resume_no_vec: assert property (
    core_ctrl.resume |-> !core_ctrl.vector && core_ctrl.wake
                         && !($past(gie_q) && ($past(ext_any)
                              || $past(pc_flag))))
    else $error("resume and vector disagree with global state");

  a_green_pin_flag: assert property (
    !sleepish && !gie_q && in_rise[`WIG_IN_EXT1] && cfg_q.ext_int_en
    && !rst_ev |=> flags_q.ext1 && !core_ctrl.vector)
    else $error("pin event without interrupts mishandled");

  a_pc_no_wake: assert property (
    sleepish && pc_ev && !cfg_q.pc_wake_en && !ext_any && !rst_ev
    |=> !core_ctrl.wake && !core_ctrl.osc_run)
    else $error("port change woke core with wake enable clear");

  a_pc_no_int: assert property (
    !sleepish && pc_ev && !cfg_q.pc_int_en && !ext_any |=> !core_ctrl.vector)
    else $error("port change interrupted with enable clear");

  a_pc_flag_only: assert property (
    sleepish && pc_ev && cfg_q.pc_int_en && !cfg_q.pc_wake_en && !ext_any
    && !rst_ev |=> flags_q.pc && !core_ctrl.wake)
    else $error("port change flag without wake mishandled");

  a_pc_wakes: assert property (
    s_low_power_change |=> s_woken_running)
    else $error("port change did not wake and restart clocks");

  a_flag_sticky: assert property (
    flags_q.pc && !clr_pc |=> flags_q.pc)
    else $error("pending flag dropped without software clear");

  a_irq_level: assert property (
    ##1 irq == |(evt_stat_q & evt_en_q))
    else $error("interrupt output disagrees with status and enable");

endmodule // wig_wake_gate
`default_nettype wire

// ===== test/wig_wake_gate_bench.sv
// Self-checking testbench of the wake and interrupt gating block
`timescale 1ns/1ps
`default_nettype none
`include "wig_defs.svh"

`define WIG_CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end

module wig_wake_gate_bench
  import wig_pkg::*;
;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        pin0;
  logic        pin1;
  logic [7:0]  port6;
  logic        wdog;
  logic        lvr;
  logic        gie_on;
  logic        gie_off;
  wig_core_s   core_ctrl;
  logic        irq;
  logic [3:0]  seen;
  logic        osc_seen;
  int          mismatches;
  int          checked;

  wig_wake_gate DUT (
    .aclk                   (aclk),
    .aresetn                (aresetn),
    .s_axi_awaddr           (awaddr),
    .s_axi_awvalid          (awvalid),
    .s_axi_awready          (awready),
    .s_axi_wdata            (wdata),
    .s_axi_wstrb            (wstrb),
    .s_axi_wvalid           (wvalid),
    .s_axi_wready           (wready),
    .s_axi_bresp            (bresp),
    .s_axi_bvalid           (bvalid),
    .s_axi_bready           (bready),
    .s_axi_araddr           (araddr),
    .s_axi_arvalid          (arvalid),
    .s_axi_arready          (arready),
    .s_axi_rdata            (rdata),
    .s_axi_rresp            (rresp),
    .s_axi_rvalid           (rvalid),
    .s_axi_rready           (rready),
    .external_pin0          (pin0),
    .external_pin1          (pin1),
    .port6                  (port6),
    .watchdog_timer_timeout (wdog),
    .low_voltage_reset      (lvr),
    .global_int_on_instr    (gie_on),
    .global_int_off_instr   (gie_off),
    .core_ctrl              (core_ctrl),
    .irq                    (irq)
  );

  initial
  begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'h0;
      if (wvalid && wready)
        wvalid <= 1'h0;
    end
    while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask

  task automatic wrq(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'h0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `WIG_CHK(d & m, e)
  endtask

  // Clear state, program enables and global interrupt, then enter mode
  task automatic setup(input logic [1:0] m, input logic [31:0] wen,
                       input logic [31:0] ien, input logic g);
    wrq(`WIG_ADDR_FLAG1, 32'h3);
    wrq(`WIG_ADDR_FLAG2, 32'h1);
    wrq(`WIG_ADDR_EVT_CLR, 32'h7);
    wrq(`WIG_ADDR_WAKE_EN, wen);
    wrq(`WIG_ADDR_INT_EN, ien);
    @(posedge aclk);
    if (g)
      gie_on <= 1'h1;
    else
      gie_off <= 1'h1;
    @(posedge aclk);
    gie_on  <= 1'h0;
    gie_off <= 1'h0;
    wrq(`WIG_ADDR_MODE, {30'h0, m});
    repeat (3) @(posedge aclk);
  endtask

  // Source: 0 pin0, 1 pin1, 2 port change, 3 watchdog, 4 low voltage
  task automatic fire(input int src);
    @(posedge aclk);
    case (src)
      0: pin0 <= 1'h1;
      1: pin1 <= 1'h1;
      2: port6 <= port6 ^ 8'h01;
      3: wdog <= 1'h1;
      default: lvr <= 1'h1;
    endcase
    seen = 4'h0;
    osc_seen = 1'h0;
    repeat (10)
    begin
      @(posedge aclk);
      seen |= {core_ctrl.wake, core_ctrl.vector, core_ctrl.resume,
               core_ctrl.reset};
      osc_seen |= core_ctrl.osc_run;
    end
    pin0 <= 1'h0;
    pin1 <= 1'h0;
    wdog <= 1'h0;
    lvr  <= 1'h0;
    repeat (6) @(posedge aclk);
  endtask

  // Events are {wake, vector, resume, reset}
  task automatic run(input int src, input logic [3:0] ev,
                     input logic [1:0] f1, input logic f2,
                     input logic [1:0] m);
    fire(src);
    `WIG_CHK(seen, ev)
    chk_rd(`WIG_ADDR_FLAG1, 32'h3, {30'h0, f1});
    chk_rd(`WIG_ADDR_FLAG2, 32'h1, {31'h0, f2});
    chk_rd(`WIG_ADDR_STATUS, 32'h6, {29'h0, m, 1'h0});
  endtask

  task automatic s_reset;
    chk_rd(`WIG_ADDR_MODE, 32'h3, 32'h0);
    chk_rd(`WIG_ADDR_STATUS, 32'h7, 32'h0);
    `WIG_CHK(core_ctrl.osc_run, 1'h1)
    `WIG_CHK(irq, 1'h0)
  endtask

  task automatic s_ext_idle;
    setup(WIG_IDLE, 32'h0, 32'h4, 1'h0);
    run(0, 4'hA, 2'h1, 1'h0, WIG_NORMAL);
  endtask

  task automatic s_ext_sleep;
    setup(WIG_SLEEP, 32'h0, 32'h4, 1'h1);
    run(0, 4'h0, 2'h0, 1'h0, WIG_SLEEP);
    `WIG_CHK(osc_seen, 1'h0)
  endtask

  task automatic s_ext_green;
    setup(WIG_GREEN, 32'h0, 32'h4, 1'h1);
    run(0, 4'h4, 2'h1, 1'h0, WIG_GREEN);
    `WIG_CHK(core_ctrl.vec_addr, `WIG_VEC_ADDR)
    repeat (20) @(posedge aclk);
    chk_rd(`WIG_ADDR_FLAG1, 32'h3, 32'h1);
  endtask

  task automatic s_ext1_normal;
    setup(WIG_NORMAL, 32'h0, 32'h4, 1'h0);
    run(1, 4'h0, 2'h0, 1'h1, WIG_NORMAL);
  endtask

  task automatic s_pc_none;
    setup(WIG_SLEEP, 32'h0, 32'h0, 1'h1);
    run(2, 4'h0, 2'h0, 1'h0, WIG_SLEEP);
    `WIG_CHK(osc_seen, 1'h0)
  endtask

  task automatic s_pc_int_only;
    setup(WIG_IDLE, 32'h0, 32'h2, 1'h1);
    run(2, 4'h0, 2'h2, 1'h0, WIG_IDLE);
    `WIG_CHK(osc_seen, 1'h0)
  endtask

  task automatic s_pc_wake_only;
    setup(WIG_SLEEP, 32'h10, 32'h0, 1'h1);
    run(2, 4'hA, 2'h0, 1'h0, WIG_NORMAL);
  endtask

  task automatic s_pc_wake_vec;
    setup(WIG_SLEEP, 32'h10, 32'h2, 1'h1);
    run(2, 4'hC, 2'h2, 1'h0, WIG_NORMAL);
  endtask

  task automatic s_pc_normal_off;
    setup(WIG_NORMAL, 32'h10, 32'h0, 1'h1);
    run(2, 4'h0, 2'h0, 1'h0, WIG_NORMAL);
  endtask

  task automatic s_reset_events;
    setup(WIG_SLEEP, 32'h10, 32'h2, 1'h1);
    run(3, 4'h1, 2'h0, 1'h0, WIG_NORMAL);
    setup(WIG_GREEN, 32'h0, 32'h4, 1'h1);
    run(4, 4'h1, 2'h0, 1'h0, WIG_NORMAL);
  endtask

  task automatic s_irq_and_bus;
    logic [31:0] d;
    logic [1:0]  r;
    setup(WIG_IDLE, 32'h0, 32'h4, 1'h0);
    wrq(`WIG_ADDR_EVT_EN, 32'h1);
    run(0, 4'hA, 2'h1, 1'h0, WIG_NORMAL);
    chk_rd(`WIG_ADDR_EVT_STAT, 32'h7, 32'h1);
    `WIG_CHK(irq, 1'h1)
    wrq(`WIG_ADDR_EVT_EN, 32'h0);
    repeat (2) @(posedge aclk);
    `WIG_CHK(irq, 1'h0)
    wrq(`WIG_ADDR_EVT_EN, 32'h1);
    repeat (2) @(posedge aclk);
    `WIG_CHK(irq, 1'h1)
    wrq(`WIG_ADDR_EVT_CLR, 32'h1);
    repeat (2) @(posedge aclk);
    `WIG_CHK(irq, 1'h0)
    chk_rd(`WIG_ADDR_EVT_STAT, 32'h7, 32'h0);
    wrq(`WIG_ADDR_FLAG1, 32'h1);
    chk_rd(`WIG_ADDR_FLAG1, 32'h3, 32'h0);
    wr(`WIG_ADDR_STATUS, 32'h1, r);
    `WIG_CHK(r, `WIG_RESP_SLVERR)
    rd(8'h40, d, r);
    `WIG_CHK(r, `WIG_RESP_SLVERR)
    `WIG_CHK(d, 32'h0)
  endtask

  initial
  begin
    mismatches = 0;
    checked = 0;
    aresetn = 1'h0;
    awaddr = 8'h0;
    awvalid = 1'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'h0;
    bready = 1'h0;
    araddr = 8'h0;
    arvalid = 1'h0;
    rready = 1'h0;
    pin0 = 1'h0;
    pin1 = 1'h0;
    port6 = 8'h0;
    wdog = 1'h0;
    lvr = 1'h0;
    gie_on = 1'h0;
    gie_off = 1'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    s_reset();
    s_ext_idle();
    s_ext_sleep();
    s_ext_green();
    s_ext1_normal();
    s_pc_none();
    s_pc_int_only();
    s_pc_wake_only();
    s_pc_wake_vec();
    s_pc_normal_off();
    s_reset_events();
    s_irq_and_bus();
    wrap_up();
  end

  // Whole run needs about 700 cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    wrap_up();
  end

endmodule // wig_wake_gate_bench
`default_nettype wire
